// *** hw/cip_defs.svh ***
`ifndef CIP_DEFS_SVH
`define CIP_DEFS_SVH

// ----------------------------------------
// Port addresses
// ----------------------------------------
`define CIP_MASTER_CMD   12'h020
`define CIP_MASTER_DATA  12'h021
`define CIP_SLAVE_CMD    12'h0A0
`define CIP_SLAVE_DATA   12'h0A1
`define CIP_MASTER_TRIG  12'h4D0
`define CIP_SLAVE_TRIG   12'h4D1

// ----------------------------------------
// Command word field positions
// ----------------------------------------
`define CIP_W1_FLAG      4
`define CIP_W3_FLAG      3
`define CIP_W2_ROT       7
`define CIP_W2_SEL       6
`define CIP_W2_EOI       5
`define CIP_W4_AUTO      1
`define CIP_W4_SFNM      4
`define CIP_W3_SMM_EN    6
`define CIP_W3_SMM       5
`define CIP_W3_RD_EN     1
`define CIP_W3_RD_IS     0

// ----------------------------------------
// Reset and fixed values
// ----------------------------------------
`define CIP_LOW_RST      3'h7
`define CIP_DEFAULT_LVL  3'h7
`define CIP_CASC_INPUT   3'h2
`define CIP_CASC_CODE    3'h2
`define CIP_ZERO8        8'h00

// ----------------------------------------
// Start-up and end-of-service programming values
// ----------------------------------------
`define CIP_V_INIT1      8'h11
`define CIP_V_M_BASE     8'h08
`define CIP_V_M_CASC     8'h04
`define CIP_V_S_BASE     8'h70
`define CIP_V_S_ID       8'h02
`define CIP_V_INIT4      8'h01
`define CIP_V_INIT4_AUTO 8'h03
`define CIP_V_SFNM       8'h10
`define CIP_V_EOI        8'h20
`define CIP_V_RD_IS      8'h0B

`endif

// *** hw/cip_pkg.sv ***
package cip_pkg;

  // Acknowledge sequencer, one bit changes per step except the return from TWO to IDLE
  typedef enum logic [1:0] {
    CIP_ACK_IDLE = 2'h0,
    CIP_ACK_ONE  = 2'h1,
    CIP_ACK_TWO  = 2'h3
  } cip_ack_type;

  // Host program operations
  typedef enum logic [1:0] {
    CIP_OP_END = 2'h0,
    CIP_OP_WR  = 2'h1,
    CIP_OP_RD  = 2'h3
  } cip_kind_type;

  typedef struct packed {
    cip_kind_type kind;
    logic [11:0]  addr;
    logic [7:0]   data;
  } cip_op_type;

  // Highest-priority set bit given the lowest level; {found, level}
  function automatic logic [3:0] cip_highest(input logic [7:0] v,
                                             input logic [2:0] low);
    logic [2:0] l;
    logic [3:0] r;
    r = 4'h0;
    for (int k = 7; k >= 0; k--)
    begin
      l = 3'(low + 3'h1 + 3'(k));
      if (v[l])
        r = {1'b1, l};
    end
    return r;
  endfunction : cip_highest

endpackage : cip_pkg

// *** hw/cip_link_if.sv ***
`timescale 1ns/1ps

interface cip_link_if;
  logic        io_wr;
  logic        io_rd;
  logic [11:0] io_addr;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        int_req;
  logic        ack_pulse;
  logic        ack_valid;
  logic [7:0]  ack_vector;

  modport dev  (input io_wr, io_rd, io_addr, io_wdata, ack_pulse,
                output io_rdata, int_req, ack_valid, ack_vector);
  modport host (output io_wr, io_rd, io_addr, io_wdata, ack_pulse,
                input io_rdata, int_req, ack_valid, ack_vector);
endinterface : cip_link_if

// *** hw/cip_dev.sv ***
`timescale 1ns/1ps
`include "cip_defs.svh"

// ----------------------------------------
// One eight-level controller
// ----------------------------------------
module cip_unit #(
  parameter bit IS_MASTER = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       cmd_wr,
  input  wire logic       data_wr,
  input  wire logic       trig_wr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] irq,
  input  wire logic       ack1,
  input  wire logic       ack2,
  output logic            int_out,
  output logic [7:0]      vector,
  output logic            cas_hit,
  output logic [2:0]      slave_id,
  output logic [7:0]      status,
  output logic [7:0]      mask,
  output logic [7:0]      trig
);
  logic [7:0] irr_q, isr_q, mask_q, trig_q, prev_q, casc_q;
  logic [4:0] base_q;
  logic [2:0] low_q, win_q;
  logic [1:0] step_q;
  logic       auto_q, sfnm_q, smm_q, rd_is_q, rot_auto_q;
  logic       w1, w2, w3, done_w4;
  logic [3:0] hr, hs, he;
  logic [2:0] rank_r, rank_s, tgt;
  logic [7:0] req, level_sel, ack_set, eoi_clr;
  logic       eoi_now, eoi_spec, rot_now;

  // Command decode
  assign w1 = cmd_wr && wdata[`CIP_W1_FLAG];
  assign w2 = cmd_wr && !wdata[`CIP_W1_FLAG] && !wdata[`CIP_W3_FLAG];
  assign w3 = cmd_wr && !wdata[`CIP_W1_FLAG] && wdata[`CIP_W3_FLAG];

  // Init sequencer: step 1..3 expects words two..four
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      step_q <= 2'h0;
    else if (w1)
      step_q <= 2'h1;
    else if (data_wr && step_q != 2'h0)
      step_q <= 2'(step_q + 2'h1);
  end

  assign done_w4 = data_wr && step_q == 2'h3;

  // Configuration held from init words
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      base_q <= 5'h00;
      casc_q <= 8'h00;
      auto_q <= 1'b0;
      sfnm_q <= 1'b0;
    end
    else
    begin
      if (data_wr && step_q == 2'h1)
        base_q <= wdata[7:3];
      if (data_wr && step_q == 2'h2)
        casc_q <= wdata;
      if (done_w4)
      begin
        auto_q <= wdata[`CIP_W4_AUTO];
        sfnm_q <= wdata[`CIP_W4_SFNM];
      end
    end
  end

  // Mask, special masking, read select, trigger select
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mask_q  <= 8'h00;
      smm_q   <= 1'b0;
      rd_is_q <= 1'b0;
      trig_q  <= 8'h00;
    end
    else
    begin
      if (w1)
      begin
        mask_q  <= 8'h00;
        smm_q   <= 1'b0;
        rd_is_q <= 1'b0;
      end
      else if (data_wr && step_q == 2'h0)
        mask_q <= wdata;
      if (w3 && wdata[`CIP_W3_SMM_EN])
        smm_q <= wdata[`CIP_W3_SMM];
      if (w3 && wdata[`CIP_W3_RD_EN])
        rd_is_q <= wdata[`CIP_W3_RD_IS];
      if (trig_wr)
        trig_q <= wdata;
    end
  end

  // Priority resolution; the cascade input follows the slave level
  assign level_sel = IS_MASTER ? (trig_q | 8'h04) : trig_q;
  assign req       = irr_q & ~mask_q;
  assign hr        = cip_pkg::cip_highest(req, low_q);
  assign hs        = cip_pkg::cip_highest(smm_q ? 8'h00 : isr_q, low_q);
  assign rank_r    = 3'(hr[2:0] - low_q - 3'h1);
  assign rank_s    = 3'(hs[2:0] - low_q - 3'h1);
  assign int_out   = hr[3] && (!hs[3] || rank_r < rank_s
                     || (IS_MASTER && sfnm_q
                         && hr[2:0] == `CIP_CASC_INPUT
                         && hs[2:0] == `CIP_CASC_INPUT));
  assign cas_hit   = IS_MASTER && int_out && casc_q[hr[2:0]];
  assign ack_set   = (ack1 && int_out) ? (8'h01 << hr[2:0]) : 8'h00;

  // End of service: command or automatic after second pulse
  assign eoi_now  = (w2 && wdata[`CIP_W2_EOI]) || (ack2 && auto_q);
  assign eoi_spec = w2 && wdata[`CIP_W2_SEL];
  assign he       = cip_pkg::cip_highest(isr_q & ~(smm_q ? mask_q : 8'h00),
                                         low_q);
  assign tgt      = eoi_spec ? wdata[2:0] : he[2:0];
  assign eoi_clr  = (eoi_now && !(eoi_spec && wdata[`CIP_W2_ROT])
                     && (eoi_spec || he[3])) ? (8'h01 << tgt) : 8'h00;
  assign rot_now  = eoi_now && !eoi_spec && he[3]
                    && (w2 ? wdata[`CIP_W2_ROT] : rot_auto_q);

  // Service bits; a set in the same cycle as a clear wins
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      isr_q <= 8'h00;
    else if (w1)
      isr_q <= 8'h00;
    else
      isr_q <= (isr_q & ~eoi_clr) | ack_set;
  end

  // Rotation state
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      low_q      <= `CIP_LOW_RST;
      rot_auto_q <= 1'b0;
    end
    else if (w1)
      low_q <= `CIP_LOW_RST;
    else
    begin
      if (rot_now)
        low_q <= he[2:0];
      if (w2 && !wdata[`CIP_W2_SEL] && !wdata[`CIP_W2_EOI])
        rot_auto_q <= wdata[`CIP_W2_ROT];
    end
  end

  // Request latch: edge bits arm on a rise, level bits follow input
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irr_q  <= 8'h00;
      prev_q <= 8'hFF;
    end
    else if (w1)
    begin
      irr_q  <= 8'h00;
      prev_q <= 8'hFF;  // A held-high input needs a fresh rise
    end
    else
    begin
      prev_q <= irq;
      irr_q  <= (level_sel & irq)
                | (~level_sel & ((irr_q & ~ack_set) | (irq & ~prev_q)));
    end
  end

  // Winning level, level 7 when nothing remains
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      win_q <= `CIP_DEFAULT_LVL;
    else if (ack1)
      win_q <= int_out ? hr[2:0] : `CIP_DEFAULT_LVL;
  end

  assign vector   = {base_q, win_q};
  assign slave_id = casc_q[2:0];
  assign status   = rd_is_q ? isr_q : irr_q;
  assign mask     = mask_q;
  assign trig     = trig_q;
endmodule : cip_unit

// ----------------------------------------
// Cascaded pair, device end of the link
// ----------------------------------------
module cip_dev (
  input  wire logic       clk,
  input  wire logic       nrst,
  cip_link_if.dev         link,
  input  wire logic [7:0] irq_low,
  input  wire logic [7:0] irq_high
);
  cip_pkg::cip_ack_type st_q;
  logic [7:0] m_vec, s_vec, m_stat, s_stat, m_mask, s_mask, m_trig, s_trig;
  logic [7:0] rdata_q, vec_q;
  logic [2:0] cas_q, s_id;
  logic       m_int, s_int, m_hit, cas_v_q, s_sel_q, valid_q;
  logic       m_ack1, s_ack1;

  // Acknowledge sequencer: one host pulse becomes two internal pulses
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_q <= cip_pkg::CIP_ACK_IDLE;
    else
      unique case (st_q)
        cip_pkg::CIP_ACK_IDLE:
          if (link.ack_pulse)
            st_q <= cip_pkg::CIP_ACK_ONE;
        cip_pkg::CIP_ACK_ONE: st_q <= cip_pkg::CIP_ACK_TWO;
        cip_pkg::CIP_ACK_TWO: st_q <= cip_pkg::CIP_ACK_IDLE;
        default:              st_q <= cip_pkg::CIP_ACK_IDLE;
      endcase
  end

  assign m_ack1 = link.ack_pulse && st_q == cip_pkg::CIP_ACK_IDLE;
  assign s_ack1 = st_q == cip_pkg::CIP_ACK_ONE && cas_v_q && cas_q == s_id;

  // Cascade bus and vector source
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cas_q   <= 3'h0;
      cas_v_q <= 1'b0;
      s_sel_q <= 1'b0;
      vec_q   <= 8'h00;
      valid_q <= 1'b0;
    end
    else
    begin
      if (m_ack1)
      begin
        cas_q   <= m_hit ? `CIP_CASC_CODE : 3'h0;
        cas_v_q <= m_hit;
      end
      if (st_q == cip_pkg::CIP_ACK_ONE)
        s_sel_q <= s_ack1;
      valid_q <= st_q == cip_pkg::CIP_ACK_TWO;
      if (st_q == cip_pkg::CIP_ACK_TWO)
        vec_q <= s_sel_q ? s_vec : m_vec;
    end
  end

  // Register read port; unmapped addresses read zero
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_q <= 8'h00;
    else if (link.io_rd)
      unique case (link.io_addr)
        `CIP_MASTER_CMD:  rdata_q <= m_stat;
        `CIP_MASTER_DATA: rdata_q <= m_mask;
        `CIP_SLAVE_CMD:   rdata_q <= s_stat;
        `CIP_SLAVE_DATA:  rdata_q <= s_mask;
        `CIP_MASTER_TRIG: rdata_q <= m_trig;
        `CIP_SLAVE_TRIG:  rdata_q <= s_trig;
        default:          rdata_q <= `CIP_ZERO8;
      endcase
  end

  assign link.io_rdata   = rdata_q;
  assign link.int_req    = m_int;
  assign link.ack_valid  = valid_q;
  assign link.ack_vector = vec_q;

  cip_unit #(.IS_MASTER(1'b1)) u_master (
    .clk      (clk),
    .nrst     (nrst),
    .cmd_wr   (link.io_wr && link.io_addr == `CIP_MASTER_CMD),
    .data_wr  (link.io_wr && link.io_addr == `CIP_MASTER_DATA),
    .trig_wr  (link.io_wr && link.io_addr == `CIP_MASTER_TRIG),
    .wdata    (link.io_wdata),
    .irq      ({irq_low[7:3], s_int, irq_low[1:0]}),
    .ack1     (m_ack1),
    .ack2     (st_q == cip_pkg::CIP_ACK_TWO),
    .int_out  (m_int),
    .vector   (m_vec),
    .cas_hit  (m_hit),
    .slave_id (),
    .status   (m_stat),
    .mask     (m_mask),
    .trig     (m_trig)
  );

  cip_unit #(.IS_MASTER(1'b0)) u_slave (
    .clk      (clk),
    .nrst     (nrst),
    .cmd_wr   (link.io_wr && link.io_addr == `CIP_SLAVE_CMD),
    .data_wr  (link.io_wr && link.io_addr == `CIP_SLAVE_DATA),
    .trig_wr  (link.io_wr && link.io_addr == `CIP_SLAVE_TRIG),
    .wdata    (link.io_wdata),
    .irq      (irq_high),
    .ack1     (s_ack1),
    .ack2     (st_q == cip_pkg::CIP_ACK_TWO && s_sel_q),
    .int_out  (s_int),
    .vector   (s_vec),
    .cas_hit  (),
    .slave_id (s_id),
    .status   (s_stat),
    .mask     (s_mask),
    .trig     (s_trig)
  );
endmodule : cip_dev

// *** hw/cip_host.sv ***
`timescale 1ns/1ps
`include "cip_defs.svh"

// ----------------------------------------
// Host end: bridge that programs and acknowledges
// ----------------------------------------
module cip_host (
  input  wire logic       clk,
  input  wire logic       nrst,
  cip_link_if.host        link,
  input  wire logic       init_go,
  input  wire logic       auto_en,
  input  wire logic       nest_en,
  input  wire logic [7:0] mask_master,
  input  wire logic [7:0] mask_slave,
  input  wire logic       eoi_go,
  input  wire logic       eoi_slave,
  input  wire logic       ack_go,
  output logic            busy,
  output logic            vector_valid,
  output logic [7:0]      vector
);
  localparam logic [4:0] INIT_AT  = 5'h00;
  localparam logic [4:0] EOI_M_AT = 5'h0D;
  localparam logic [4:0] EOI_S_AT = 5'h0F;

  cip_pkg::cip_op_type op;
  logic [4:0]  step_q;
  logic [1:0]  ph_q;
  logic        run_q, ackw_q, nest_q, pulse_q, wr_q, rd_q, vv_q;
  logic [11:0] addr_q;
  logic [7:0]  wdata_q, vec_q;

  // Stored programs; the slave is brought up first
  always_comb
  begin
    op = '{cip_pkg::CIP_OP_END, 12'h000, 8'h00};
    unique case (step_q)
      5'h00: op = '{cip_pkg::CIP_OP_WR, `CIP_SLAVE_CMD,  `CIP_V_INIT1};
      5'h01: op = '{cip_pkg::CIP_OP_WR, `CIP_SLAVE_DATA, `CIP_V_S_BASE};
      5'h02: op = '{cip_pkg::CIP_OP_WR, `CIP_SLAVE_DATA, `CIP_V_S_ID};
      5'h03: op = '{cip_pkg::CIP_OP_WR, `CIP_SLAVE_DATA, `CIP_V_INIT4};
      5'h04: op = '{cip_pkg::CIP_OP_WR, `CIP_SLAVE_TRIG, `CIP_ZERO8};
      5'h05: op = '{cip_pkg::CIP_OP_WR, `CIP_SLAVE_DATA, mask_slave};
      5'h06: op = '{cip_pkg::CIP_OP_WR, `CIP_MASTER_CMD, `CIP_V_INIT1};
      5'h07: op = '{cip_pkg::CIP_OP_WR, `CIP_MASTER_DATA, `CIP_V_M_BASE};
      5'h08: op = '{cip_pkg::CIP_OP_WR, `CIP_MASTER_DATA, `CIP_V_M_CASC};
      5'h09: op = '{cip_pkg::CIP_OP_WR, `CIP_MASTER_DATA,
                    (auto_en ? `CIP_V_INIT4_AUTO : `CIP_V_INIT4)
                    | (nest_en ? `CIP_V_SFNM : `CIP_ZERO8)};
      5'h0A: op = '{cip_pkg::CIP_OP_WR, `CIP_MASTER_TRIG, `CIP_ZERO8};
      5'h0B: op = '{cip_pkg::CIP_OP_WR, `CIP_MASTER_DATA, mask_master};
      5'h0D: op = '{cip_pkg::CIP_OP_WR, `CIP_MASTER_CMD, `CIP_V_EOI};
      5'h0F: op = '{cip_pkg::CIP_OP_WR, `CIP_SLAVE_CMD,  `CIP_V_EOI};
      5'h10: op = '{cip_pkg::CIP_OP_WR, `CIP_SLAVE_CMD,  `CIP_V_RD_IS};
      5'h11: op = '{cip_pkg::CIP_OP_RD, `CIP_SLAVE_CMD,  `CIP_ZERO8};
      5'h12: op = '{cip_pkg::CIP_OP_WR, `CIP_MASTER_CMD, `CIP_V_EOI};
      default: op = '{cip_pkg::CIP_OP_END, 12'h000, 8'h00};
    endcase
  end

  // Sequencer: each write or read operation takes three cycles
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      run_q <= 1'b0;
      step_q <= 5'h00;
      ph_q <= 2'h0;
      nest_q <= 1'b0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      addr_q <= 12'h000;
      wdata_q <= 8'h00;
    end
    else if (!run_q)
    begin
      ph_q <= 2'h0;
      if (!ackw_q && init_go)
      begin
        run_q  <= 1'b1;
        step_q <= INIT_AT;
        nest_q <= nest_en;
      end
      else if (!ackw_q && eoi_go)
      begin
        run_q  <= 1'b1;
        step_q <= eoi_slave ? EOI_S_AT : EOI_M_AT;
      end
    end
    else
      unique case (ph_q)
        2'h0:
        begin
          wr_q    <= op.kind == cip_pkg::CIP_OP_WR;
          rd_q    <= op.kind == cip_pkg::CIP_OP_RD;
          addr_q  <= op.addr;
          wdata_q <= op.data;
          run_q   <= op.kind != cip_pkg::CIP_OP_END;
          ph_q    <= (op.kind == cip_pkg::CIP_OP_END) ? 2'h0 : 2'h1;
        end
        2'h1:
        begin
          wr_q <= 1'b0;
          rd_q <= 1'b0;
          ph_q <= 2'h2;
        end
        default:
        begin
          ph_q <= 2'h0;
          // With nesting on, a slave still in service keeps the master untouched
          if (op.kind == cip_pkg::CIP_OP_RD && nest_q
              && link.io_rdata != `CIP_ZERO8)
            run_q <= 1'b0;
          step_q <= 5'(step_q + 5'h01);
        end
      endcase
  end

  // Acknowledge: one pulse out, vector back
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pulse_q <= 1'b0;
      ackw_q  <= 1'b0;
      vv_q    <= 1'b0;
      vec_q   <= 8'h00;
    end
    else
    begin
      pulse_q <= !run_q && !ackw_q && !init_go && !eoi_go && ack_go;
      vv_q    <= ackw_q && link.ack_valid;
      if (!run_q && !ackw_q && !init_go && !eoi_go && ack_go)
        ackw_q <= 1'b1;
      else if (link.ack_valid)
        ackw_q <= 1'b0;
      if (ackw_q && link.ack_valid)
        vec_q <= link.ack_vector;
    end
  end

  assign link.io_wr     = wr_q;
  assign link.io_rd     = rd_q;
  assign link.io_addr   = addr_q;
  assign link.io_wdata  = wdata_q;
  assign link.ack_pulse = pulse_q;
  assign busy           = run_q || ackw_q;
  assign vector_valid   = vv_q;
  assign vector         = vec_q;
endmodule : cip_host

// *** sim/cip_chk.sv ***
`timescale 1ns/1ps
`include "cip_defs.svh"

module cip_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [11:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        ack_pulse,
  input wire logic        ack_valid,
  input wire logic [7:0]  ack_vector
);
  logic slave_done_q;
  logic m_init1;
  logic s_init1;
  logic op2_wr;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // Helper decode
  // ----------------------------------------
  // Init word one seen on each command port
  assign m_init1 = io_wr && io_addr == `CIP_MASTER_CMD
                   && io_wdata[`CIP_W1_FLAG];
  assign s_init1 = io_wr && io_addr == `CIP_SLAVE_CMD
                   && io_wdata[`CIP_W1_FLAG];
  // Operation word two pattern on any write; the assertion limits it to the command ports
  assign op2_wr  = io_wr && !io_wdata[`CIP_W1_FLAG]
                   && !io_wdata[`CIP_W3_FLAG];

  // Remembers that the slave was brought up; cleared only by reset
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      slave_done_q <= 1'b0;
    else if (s_init1)
      slave_done_q <= 1'b1;
  end

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  // One write to port a whose masked value matches
  sequence s_dw(logic [11:0] a, logic [7:0] v, logic [7:0] m);
    io_wr && io_addr == a && (io_wdata & m) == v;
  endsequence

  sequence s_rd_slave;
    io_rd && io_addr == `CIP_SLAVE_CMD;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  ack_lat_a: assert property (ack_pulse |-> ##3 ack_valid)
    else $error("ack answer not three cycles after request");
  ack_once_a: assert property (ack_valid |=> !ack_valid)
    else $error("ack valid longer than one cycle");
  ack_cause_a: assert property (ack_valid |-> $past(ack_pulse, 3))
    else $error("ack valid without a request");
  vec_hold_a: assert property ($changed(ack_vector) |-> ack_valid)
    else $error("vector changed outside an answer");
  rdata_hold_a: assert property ($changed(io_rdata) |-> $past(io_rd))
    else $error("read data changed without a read");
  strobe_pulse_a: assert property (io_wr |=> !io_wr)
    else $error("write strobe longer than one cycle");
  master_init_a: assert property (m_init1 |->
    ##3 s_dw(`CIP_MASTER_DATA, `CIP_V_M_BASE, 8'hFF)
    ##3 s_dw(`CIP_MASTER_DATA, `CIP_V_M_CASC, 8'hFF)
    ##3 s_dw(`CIP_MASTER_DATA, 8'h01, 8'h01))
    else $error("master init words out of order");
  slave_init_a: assert property (s_init1 |->
    ##3 s_dw(`CIP_SLAVE_DATA, `CIP_V_S_BASE, 8'hFF)
    ##3 s_dw(`CIP_SLAVE_DATA, `CIP_V_S_ID, 8'hFF)
    ##3 s_dw(`CIP_SLAVE_DATA, 8'h01, 8'h03))
    else $error("slave init words out of order");
  slave_first_a: assert property (m_init1 |-> slave_done_q)
    else $error("master initialised before slave");
  eoi_form_a: assert property (op2_wr &&
    (io_addr == `CIP_MASTER_CMD || io_addr == `CIP_SLAVE_CMD)
    |-> io_wdata == `CIP_V_EOI)
    else $error("operation word two not a plain end command");
  slave_eoi_a: assert property (
    s_dw(`CIP_SLAVE_CMD, `CIP_V_EOI, 8'hFF) |->
    ##3 s_dw(`CIP_SLAVE_CMD, `CIP_V_RD_IS, 8'hFF) ##3 s_rd_slave)
    else $error("slave end not followed by service read");
endmodule : cip_chk

// *** sim/tb_cascaded_interrupt_priority_eoi.sv ***
`timescale 1ns/1ps
`include "cip_defs.svh"

`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("MISMATCH %s expected %h seen %h", nm, e, g); \
    end \
  end

module tb_cascaded_interrupt_priority_eoi;
  logic       clk;
  logic       nrst;
  logic [7:0] irq_low;
  logic [7:0] irq_high;
  logic       init_go;
  logic       auto_en;
  logic       nest_en;
  logic [7:0] mask_master;
  logic [7:0] mask_slave;
  logic       eoi_go;
  logic       eoi_slave;
  logic       ack_go;
  logic       busy;
  logic       vector_valid;
  logic [7:0] vector;
  logic       seen;
  int         fail_count;
  int         check_count;

  cip_link_if cip_link_if_inst ();

  cip_dev cip_dev_inst (.clk(clk), .nrst(nrst), .link(cip_link_if_inst),
    .irq_low(irq_low), .irq_high(irq_high));

  cip_host cip_host_inst (.clk(clk), .nrst(nrst), .link(cip_link_if_inst),
    .init_go(init_go), .auto_en(auto_en), .nest_en(nest_en),
    .mask_master(mask_master), .mask_slave(mask_slave), .eoi_go(eoi_go),
    .eoi_slave(eoi_slave), .ack_go(ack_go), .busy(busy),
    .vector_valid(vector_valid), .vector(vector));

  cip_chk cip_chk_inst (.clk(clk), .nrst(nrst),
    .io_wr(cip_link_if_inst.io_wr), .io_rd(cip_link_if_inst.io_rd),
    .io_addr(cip_link_if_inst.io_addr), .io_wdata(cip_link_if_inst.io_wdata),
    .io_rdata(cip_link_if_inst.io_rdata),
    .ack_pulse(cip_link_if_inst.ack_pulse),
    .ack_valid(cip_link_if_inst.ack_valid),
    .ack_vector(cip_link_if_inst.ack_vector));

  // ----------------------------------------
  // Clock and closing
  // ----------------------------------------
  // 200 MHz system clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results

  // Whole run needs a few hundred cycles; cut off well beyond that
  initial
  begin
    #100000;
    fail_count++;
    $display("watchdog expired");
    results();
  end

  // ----------------------------------------
  // Host user side helpers
  // ----------------------------------------
  // Pulse one go input, then wait for the program to finish; an ack also
  // waits for the vector pulse, which lands in the same cycle that busy falls
  task automatic go(input int k);
    int n;
    n = 0;
    seen = 1'b0;
    @(negedge clk);
    init_go = (k == 0);
    eoi_go = (k == 1);
    ack_go = (k == 2);
    @(negedge clk);
    init_go = 1'b0;
    eoi_go = 1'b0;
    ack_go = 1'b0;
    while ((busy !== 1'b0 || (k == 2 && !seen)) && n < 400)
    begin
      if (vector_valid === 1'b1)
        seen = 1'b1;
      @(negedge clk);
      n++;
    end
    `CHK("busy", 1'b0, busy);
  endtask : go

  task automatic init(input logic a, input logic s);
    auto_en = a;
    nest_en = s;
    go(0);
  endtask : init

  task automatic eoi(input logic s);
    eoi_slave = s;
    go(1);
  endtask : eoi

  // Vector is checked on the wire and at the host output
  task automatic ack(input logic [7:0] e);
    go(2);
    `CHK("vector_valid", 1'b1, seen);
    `CHK("ack_vector", e, cip_link_if_inst.ack_vector);
    `CHK("vector", e, vector);
  endtask : ack

  // A slave request needs two latch stages to reach the master output,
  // so allow a comfortable margin before looking
  task automatic int_is(input logic e);
    repeat (8) @(negedge clk);
    `CHK("int_req", e, cip_link_if_inst.int_req);
  endtask : int_is

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_default;
    init(1'b0, 1'b0);
    int_is(1'b0);
    ack(8'h0F);
    $display("done t_default");
  endtask : t_default

  task automatic t_nested;
    irq_low[5] = 1'b1;
    int_is(1'b1);
    ack(8'h0D);
    irq_low[6] = 1'b1;
    int_is(1'b0);
    irq_low[3] = 1'b1;
    int_is(1'b1);
    ack(8'h0B);
    irq_low[4] = 1'b1;
    int_is(1'b0);
    eoi(1'b0);
    int_is(1'b1);
    ack(8'h0C);
    eoi(1'b0);
    eoi(1'b0);
    int_is(1'b1);
    ack(8'h0E);
    eoi(1'b0);
    irq_low = 8'h00;
    $display("done t_nested");
  endtask : t_nested

  task automatic t_slave;
    irq_high[1] = 1'b1;
    int_is(1'b1);
    ack(8'h71);
    irq_high[0] = 1'b1;
    int_is(1'b0);
    eoi(1'b1);
    int_is(1'b1);
    ack(8'h70);
    eoi(1'b1);
    int_is(1'b0);
    irq_high = 8'h00;
    $display("done t_slave");
  endtask : t_slave

  task automatic t_auto;
    mask_master = 8'h08;
    mask_slave = 8'h02;
    init(1'b1, 1'b0);
    irq_low[3] = 1'b1;
    irq_high[1] = 1'b1;
    int_is(1'b0);
    irq_low[4] = 1'b1;
    int_is(1'b1);
    ack(8'h0C);
    irq_low[6] = 1'b1;
    int_is(1'b1);
    ack(8'h0E);
    int_is(1'b0);
    irq_low = 8'h00;
    irq_high = 8'h00;
    $display("done t_auto");
  endtask : t_auto

  task automatic t_nest;
    mask_master = 8'h00;
    mask_slave = 8'h00;
    init(1'b0, 1'b1);
    irq_high[5] = 1'b1;
    int_is(1'b1);
    ack(8'h75);
    irq_high[2] = 1'b1;
    int_is(1'b1);
    ack(8'h72);
    eoi(1'b1);
    irq_low[4] = 1'b1;
    int_is(1'b0);
    eoi(1'b1);
    int_is(1'b1);
    ack(8'h0C);
    eoi(1'b0);
    irq_low = 8'h00;
    irq_high = 8'h00;
    $display("done t_nest");
  endtask : t_nest

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    fail_count = 0;
    check_count = 0;
    nrst = 1'b0;
    irq_low = 8'h00;
    irq_high = 8'h00;
    init_go = 1'b0;
    auto_en = 1'b0;
    nest_en = 1'b0;
    mask_master = 8'h00;
    mask_slave = 8'h00;
    eoi_go = 1'b0;
    eoi_slave = 1'b0;
    ack_go = 1'b0;
    seen = 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    t_default();
    t_nested();
    t_slave();
    t_auto();
    t_nest();
    results();
  end
endmodule : tb_cascaded_interrupt_priority_eoi
